// file: core/fdpi_pkg.sv
/*
 * Constants, types and field layouts shared by the floppy drive pin
 * interface. Assumes one 200 MHz clock and a controller core that
 * presents active-high drive requests.
 */
// Behaviour
// - Printer mode: pins 3..7 carry data bits
// - Extension modes: pin 3 is second read data
// - Extension modes: pin 4 is second disk change
// - Single: pins 5..7 float; dual: 5 floats
// - Dual: pin 6 mirrors motor A, open drain
// - Dual: pin 7 mirrors select A, open drain
// - Two-bit field picks density-1 pin role
// - Head pin released side 0, low side 1
// - Direction released outward, low inward
// - One low step pulse per track move
// - Motor A/B low enable drive 0/1
// - Select A/B low enable drive A/B
// - Write data low, qualified by write enable
// - Config bit 7 removes input pull-ups
package fdpi_pkg;

    // ==========================================================
    // Modes and pin functions
    typedef enum logic [1:0] {
        PPM_PRINTER = 2'h0,
        PPM_EXT1    = 2'h1,
        PPM_EXT2    = 2'h2
    } fdpi_pp_mode_t;

    typedef enum logic [1:0] {
        FN_DENSITY = 2'h0,
        FN_GPIO    = 2'h1,
        FN_KBC     = 2'h2,
        FN_SCI     = 2'h3
    } fdpi_den1_fn_t;

    // ==========================================================
    // Field positions and reset values
    localparam int CFG_W          = 8;
    localparam int PUD_BIT        = 7;
    localparam int PD_W           = 5;
    localparam int PD_RDATA       = 0;   // par_data_3
    localparam int PD_DISK_CHANGE_N      = 1;   // par_data_4
    localparam int PD_SPARE       = 2;   // par_data_5
    localparam int PD_MOTOR       = 3;   // par_data_6
    localparam int PD_SELECT      = 4;   // par_data_7
    localparam logic RST_PULLUP   = 1'h1;
    localparam logic PIN_LOW      = 1'h0;
    localparam logic IN_IDLE      = 1'h1;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_PS  = 5000;
    localparam int STEP_PULSE_NS  = 1000;
    localparam int STEP_GAP_NS    = 1000;
    localparam int STEP_PULSE_CYC =
        (STEP_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int STEP_GAP_CYC   =
        (STEP_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int STEP_CNT_W     = 16;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic       head_side1;
        logic       dir_inward;
        logic       step_req;
        logic       motor_a;
        logic       motor_b;
        logic       select_a;
        logic       select_b;
        logic       write_en;
        logic       write_data;
        logic [1:0] density;
    } fdpi_core_cmd_t;

    typedef struct packed {
        logic head;
        logic dir;
        logic step;
        logic motor_a;
        logic motor_b;
        logic select_a;
        logic select_b;
        logic write_en;
        logic write_serial;
        logic density0;
    } fdpi_od_t;

    typedef struct packed {
        logic disk_change_n;
        logic read_data_n;
        logic write_prot_n;
        logic track_zero_n;
        logic index_n;
    } fdpi_drv_in_t;

    typedef struct packed {
        logic gpio_o;
        logic gpio_oe;
        logic kbc_o;
        logic kbc_oe;
        logic sci_assert;
    } fdpi_alt_t;

endpackage : fdpi_pkg

// file: core/fdpi_step_gen.sv
/*
 * Step pulse generator: one low pulse of fixed width per request.
 * Assumes step_req is a one-cycle pulse; one request arriving during
 * a pulse or its recovery gap is held and issued afterwards.
 */
`timescale 1ns/1ps
`default_nettype none
module fdpi_step_gen
    import fdpi_pkg::*;
#(
    parameter int PULSE_CYC = STEP_PULSE_CYC,
    parameter int GAP_CYC   = STEP_GAP_CYC
) (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic step_req,
    output logic      step_low
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_LOW  = 2'h1,
        ST_GAP  = 2'h2
    } fdpi_step_st_t;

    fdpi_step_st_t          state;
    logic [STEP_CNT_W-1:0]  cnt;
    logic                   pending;

    localparam logic [STEP_CNT_W-1:0] PULSE_LAST = STEP_CNT_W'(PULSE_CYC - 1);
    localparam logic [STEP_CNT_W-1:0] GAP_LAST   = STEP_CNT_W'(GAP_CYC - 1);
    localparam logic [STEP_CNT_W-1:0] PULSE_LEN  = STEP_CNT_W'(PULSE_CYC);

    // ==========================================================
    // Pulse sequencer
    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= ST_IDLE;
            cnt   <= '0;
        end else begin
            case (state)
                ST_IDLE: begin
                    cnt <= '0;
                    if (step_req || pending) begin
                        state <= ST_LOW;
                    end
                end
                ST_LOW: begin
                    if (cnt == PULSE_LAST) begin
                        state <= ST_GAP;
                        cnt   <= '0;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                ST_GAP: begin
                    if (cnt == GAP_LAST) begin
                        state <= ST_IDLE;
                        cnt   <= '0;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    cnt   <= '0;
                end
            endcase
        end
    end

    // Request during a pulse must not be lost: set wins over consume
    always_ff @(posedge mclk) begin
        if (rst) begin
            pending <= 1'b0;
        end else if (step_req && state != ST_IDLE) begin
            pending <= 1'b1;
        end else if (state == ST_IDLE) begin
            pending <= 1'b0;
        end
    end

    assign step_low = (state == ST_LOW);

    // ==========================================================
    // Checks
    logic [STEP_CNT_W-1:0] chk_width;
    always_ff @(posedge mclk) begin
        if (rst || !step_low) begin
            chk_width <= '0;
        end else begin
            chk_width <= chk_width + 1'b1;
        end
    end

    property p_step_width;
        @(posedge mclk) disable iff (rst)
        $fell(step_low) |-> chk_width == PULSE_LEN;
    endproperty
    a_step_width: assert property (p_step_width)
        else $error("step pulse width wrong");

    property p_step_start;
        @(posedge mclk) disable iff (rst)
        (state == ST_IDLE && step_req) |=> step_low;
    endproperty
    a_step_start: assert property (p_step_start)
        else $error("step request gave no pulse");

    c_step_queued: cover property (@(posedge mclk) disable iff (rst)
        step_low && step_req);

endmodule : fdpi_step_gen
`default_nettype wire

// file: core/fdpi_den1_mux.sv
/*
 * Role selection for the density-select-1 pin.
 * Combinational; the caller registers pin outputs and inputs.
 */
`timescale 1ns/1ps
`default_nettype none
module fdpi_den1_mux
    import fdpi_pkg::*;
(
    input  wire fdpi_den1_fn_t fn,
    input  wire logic          density1,
    input  wire fdpi_alt_t     alt,
    input  wire logic          pin_i,
    output logic               pin_o,
    output logic               pin_oe,
    output logic               gpio_in,
    output logic               kbc_in
);
    // ==========================================================
    // Role decode
    always_comb begin
        pin_o   = PIN_LOW;
        pin_oe  = 1'b0;
        gpio_in = IN_IDLE;
        kbc_in  = IN_IDLE;
        case (fn)
            FN_DENSITY: begin
                pin_oe = ~density1;
            end
            FN_GPIO: begin
                pin_o   = alt.gpio_o;
                pin_oe  = alt.gpio_oe;
                gpio_in = pin_i;
            end
            FN_KBC: begin
                pin_o  = alt.kbc_o;
                pin_oe = alt.kbc_oe;
                kbc_in = pin_i;
            end
            FN_SCI: begin
                // Push-pull, active low
                pin_o  = ~alt.sci_assert;
                pin_oe = 1'b1;
            end
            default: begin
                pin_oe = 1'b0;
            end
        endcase
    end

endmodule : fdpi_den1_mux
`default_nettype wire

// file: core/fdpi_top.sv
/*
 * Floppy drive pin interface: primary drive outputs, input pull-up
 * control, density-1 pin role, and reuse of parallel data pins 3..7
 * as a second drive interface in the extension modes.
 * Assumes pins are synchronous to mclk and that the controller core
 * and parallel port live outside this block.
 */
`timescale 1ns/1ps
`default_nettype none
module fdpi_top
    import fdpi_pkg::*;
#(
    parameter int PULSE_CYC = STEP_PULSE_CYC,
    parameter int GAP_CYC   = STEP_GAP_CYC
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire fdpi_pp_mode_t    pp_mode,
    input  wire logic [1:0]       pin_function_cfg,
    input  wire logic [CFG_W-1:0] floppy_cfg_reg,
    input  wire fdpi_core_cmd_t   core_cmd,
    input  wire fdpi_alt_t        alt_out,
    input  wire logic [PD_W-1:0]  pp_data_out,
    input  wire logic             pp_data_drive,
    output logic [PD_W-1:0]       pp_data_in,
    output fdpi_od_t              drv_o,
    output fdpi_od_t              drv_oe,
    input  wire fdpi_drv_in_t     drv_in,
    output fdpi_drv_in_t          core_drv_in,
    output logic                  input_pullup_en,
    input  wire logic             density_sel_1_i,
    output logic                  density_sel_1_o,
    output logic                  density_sel_1_oe,
    output logic                  gpio_port1_bit0,
    output logic                  kbc_port_bit,
    input  wire logic [PD_W-1:0]  par_data_i,
    output logic [PD_W-1:0]       par_data_o,
    output logic [PD_W-1:0]       par_data_oe,
    output logic                  ext_read_data_n,
    output logic                  ext_disk_change_n
);
    fdpi_od_t  od_reg;
    logic      step_low;
    logic      den1_o;
    logic      den1_oe;
    logic      gpio_in;
    logic      kbc_in;
    logic      ext_mode;

    assign ext_mode = (pp_mode == PPM_EXT1) || (pp_mode == PPM_EXT2);

    // ==========================================================
    // Step pulse
    fdpi_step_gen #(
        .PULSE_CYC (PULSE_CYC),
        .GAP_CYC   (GAP_CYC)
    ) u_step (
        .mclk     (mclk),
        .rst      (rst),
        .step_req (core_cmd.step_req),
        .step_low (step_low)
    );

    // ==========================================================
    // Primary open-drain outputs; enable means pin pulled low
    always_ff @(posedge mclk) begin
        if (rst) begin
            od_reg <= '0;
        end else begin
            od_reg.head         <= core_cmd.head_side1;
            od_reg.dir          <= core_cmd.dir_inward;
            od_reg.step         <= 1'b0;
            od_reg.motor_a      <= core_cmd.motor_a;
            od_reg.motor_b      <= core_cmd.motor_b;
            od_reg.select_a     <= core_cmd.select_a;
            od_reg.select_b     <= core_cmd.select_b;
            od_reg.write_en     <= core_cmd.write_en;
            // Data outside a write window would corrupt the track
            od_reg.write_serial <= core_cmd.write_data
                                 & core_cmd.write_en;
            od_reg.density0     <= ~core_cmd.density[0];
        end
    end

    always_comb begin
        drv_oe      = od_reg;
        drv_oe.step = step_low;
    end

    // Open drain never drives high
    assign drv_o = '0;

    // ==========================================================
    // Primary inputs and pull-up control
    always_ff @(posedge mclk) begin
        if (rst) begin
            core_drv_in <= '1;
        end else begin
            core_drv_in <= drv_in;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            input_pullup_en <= RST_PULLUP;
        end else begin
            input_pullup_en <= ~floppy_cfg_reg[PUD_BIT];
        end
    end

    // ==========================================================
    // Density-select-1 pin role
    fdpi_den1_mux u_den1 (
        .fn       (fdpi_den1_fn_t'(pin_function_cfg)),
        .density1 (core_cmd.density[1]),
        .alt      (alt_out),
        .pin_i    (density_sel_1_i),
        .pin_o    (den1_o),
        .pin_oe   (den1_oe),
        .gpio_in  (gpio_in),
        .kbc_in   (kbc_in)
    );

    always_ff @(posedge mclk) begin
        if (rst) begin
            density_sel_1_o  <= PIN_LOW;
            density_sel_1_oe <= 1'b0;
            gpio_port1_bit0  <= IN_IDLE;
            kbc_port_bit     <= IN_IDLE;
        end else begin
            density_sel_1_o  <= den1_o;
            density_sel_1_oe <= den1_oe;
            gpio_port1_bit0  <= gpio_in;
            kbc_port_bit     <= kbc_in;
        end
    end

    // ==========================================================
    // Parallel data pins 3..7
    always_ff @(posedge mclk) begin
        if (rst) begin
            par_data_o  <= '0;
            par_data_oe <= '0;
        end else begin
            case (pp_mode)
                PPM_EXT1: begin
                    // Inputs on 3 and 4, nothing driven
                    par_data_o  <= '0;
                    par_data_oe <= '0;
                end
                PPM_EXT2: begin
                    par_data_o  <= '0;
                    par_data_oe <= '0;
                    par_data_oe[PD_MOTOR]  <= core_cmd.motor_a;
                    par_data_oe[PD_SELECT] <= core_cmd.select_a;
                end
                default: begin
                    par_data_o  <= pp_data_out;
                    par_data_oe <= {PD_W{pp_data_drive}};
                end
            endcase
        end
    end

    // ==========================================================
    // Inputs from pins 3..7
    always_ff @(posedge mclk) begin
        if (rst) begin
            ext_read_data_n   <= IN_IDLE;
            ext_disk_change_n <= IN_IDLE;
            pp_data_in        <= '0;
        end else if (ext_mode) begin
            ext_read_data_n   <= par_data_i[PD_RDATA];
            ext_disk_change_n <= par_data_i[PD_DISK_CHANGE_N];
            pp_data_in        <= '0;
        end else begin
            ext_read_data_n   <= IN_IDLE;
            ext_disk_change_n <= IN_IDLE;
            pp_data_in        <= par_data_i;
        end
    end

    // ==========================================================
    // Checks
    property p_printer_data;
        @(posedge mclk) disable iff (rst)
        (pp_mode == PPM_PRINTER) |=>
            par_data_o == $past(pp_data_out) &&
            par_data_oe == {PD_W{$past(pp_data_drive)}};
    endproperty
    a_printer_data: assert property (p_printer_data)
        else $error("printer data not on pins");

    property p_ext_rdata;
        @(posedge mclk) disable iff (rst)
        ext_mode ##1 ext_mode |->
            ext_read_data_n == $past(par_data_i[PD_RDATA]) &&
            !par_data_oe[PD_RDATA];
    endproperty
    a_ext_rdata: assert property (p_ext_rdata)
        else $error("second read data not passed");

    property p_ext_disk_change_n;
        @(posedge mclk) disable iff (rst)
        ext_mode |=>
            ext_disk_change_n == $past(par_data_i[PD_DISK_CHANGE_N]) &&
            !par_data_oe[PD_DISK_CHANGE_N];
    endproperty
    a_ext_disk_change_n: assert property (p_ext_disk_change_n)
        else $error("second disk change not passed");

    property p_ext_float;
        @(posedge mclk) disable iff (rst)
        (pp_mode == PPM_EXT1) |=> par_data_oe == '0;
    endproperty
    a_ext_float: assert property (p_ext_float)
        else $error("pin driven in single extension mode");

    property p_dual_spare;
        @(posedge mclk) disable iff (rst)
        (pp_mode == PPM_EXT2) |=> !par_data_oe[PD_SPARE];
    endproperty
    a_dual_spare: assert property (p_dual_spare)
        else $error("pin 5 driven in dual mode");

    property p_dual_motor;
        @(posedge mclk) disable iff (rst)
        (pp_mode == PPM_EXT2) |=>
            par_data_oe[PD_MOTOR] == drv_oe.motor_a &&
            !par_data_o[PD_MOTOR];
    endproperty
    a_dual_motor: assert property (p_dual_motor)
        else $error("extension motor A not mirrored");

    property p_dual_select;
        @(posedge mclk) disable iff (rst)
        (pp_mode == PPM_EXT2) |=>
            par_data_oe[PD_SELECT] == drv_oe.select_a &&
            !par_data_o[PD_SELECT];
    endproperty
    a_dual_select: assert property (p_dual_select)
        else $error("extension select A not mirrored");

    property p_den1_sci;
        @(posedge mclk) disable iff (rst)
        (pin_function_cfg == FN_SCI) |=>
            density_sel_1_oe &&
            density_sel_1_o == !$past(alt_out.sci_assert);
    endproperty
    a_den1_sci: assert property (p_den1_sci)
        else $error("interrupt role not on density pin");

    property p_den1_density;
        @(posedge mclk) disable iff (rst)
        (pin_function_cfg == FN_DENSITY) |=>
            density_sel_1_oe == !$past(core_cmd.density[1]) &&
            !density_sel_1_o;
    endproperty
    a_den1_density: assert property (p_den1_density)
        else $error("density bit 1 wrong on pin");

    property p_head_dir;
        @(posedge mclk) disable iff (rst)
        ##1 drv_oe.head == $past(core_cmd.head_side1) &&
            drv_oe.dir == $past(core_cmd.dir_inward);
    endproperty
    a_head_dir: assert property (p_head_dir)
        else $error("head or direction level wrong");

    property p_write_qual;
        @(posedge mclk) disable iff (rst)
        drv_oe.write_serial |-> drv_oe.write_en;
    endproperty
    a_write_qual: assert property (p_write_qual)
        else $error("write data outside write enable");

    property p_pullup;
        @(posedge mclk) disable iff (rst)
        floppy_cfg_reg[PUD_BIT] |=> !input_pullup_en;
    endproperty
    a_pullup: assert property (p_pullup)
        else $error("pull-ups not removed");

    property p_od_release;
        @(posedge mclk) disable iff (rst)
        (pp_mode == PPM_EXT2) |=> drv_o == '0 &&
            par_data_o[PD_MOTOR] == PIN_LOW &&
            par_data_o[PD_SELECT] == PIN_LOW;
    endproperty
    a_od_release: assert property (p_od_release)
        else $error("open drain pin driven high");

    c_printer: cover property (@(posedge mclk) disable iff (rst)
        pp_mode == PPM_PRINTER && pp_data_drive);
    c_dual_motor: cover property (@(posedge mclk) disable iff (rst)
        pp_mode == PPM_EXT2 && par_data_oe[PD_MOTOR]);
    c_sci: cover property (@(posedge mclk) disable iff (rst)
        pin_function_cfg == FN_SCI && density_sel_1_o == PIN_LOW);
    c_step: cover property (@(posedge mclk) disable iff (rst)
        $rose(drv_oe.step));

endmodule : fdpi_top
`default_nettype wire

// file: test/fdpi_drive_model.sv
/*
 * Behavioural floppy drive: turns media state into the drive's
 * active-low status lines. Assumes the bench sets the media state.
 */
`timescale 1ns/1ps
`default_nettype none
module fdpi_drive_model
    import fdpi_pkg::*;
(
    input  wire logic    mclk,
    input  wire logic    removed,
    input  wire logic    prot,
    input  wire logic    outer,
    input  wire logic    hole,
    input  wire logic    rd_pulse,
    output fdpi_drv_in_t drv_in
);
    // ==========================================================
    // Status lines, changed just after the edge like a real drive
    always_ff @(posedge mclk) begin
        drv_in.disk_change_n <= !removed;
        drv_in.write_prot_n  <= !prot;
        drv_in.track_zero_n  <= !outer;
        drv_in.index_n       <= !hole;
        drv_in.read_data_n   <= !rd_pulse;
    end
endmodule : fdpi_drive_model
`default_nettype wire

// file: test/testbench.sv
/*
 * Self-checking bench for the floppy drive pin interface.
 * Assumes one drive model on the primary pins; the bench plays the
 * second drive on the parallel data pins.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import fdpi_pkg::*;
    // Short step pulse keeps the run brief
    localparam int PC = 2;
    logic           mclk, rst, pp_data_drive, density_sel_1_i;
    fdpi_pp_mode_t  pp_mode;
    logic [1:0]     pin_function_cfg;
    logic [7:0]     floppy_cfg_reg;
    fdpi_core_cmd_t core_cmd;
    fdpi_alt_t      alt_out;
    logic [4:0]     pp_data_out, pp_data_in, par_data_i, par_data_o;
    logic [4:0]     par_data_oe;
    fdpi_od_t       drv_o, drv_oe;
    fdpi_drv_in_t   drv_in, core_drv_in;
    logic           input_pullup_en, den1_o, den1_oe, gpio_b, kbc_b;
    logic           ext_rd_n, ext_dc_n, removed, prot, outer, hole, rd;
    int             n_mismatch, checked, nstep, nrise;
    logic           prev;

    fdpi_drive_model drv (.mclk(mclk), .removed(removed), .prot(prot),
        .outer(outer), .hole(hole), .rd_pulse(rd), .drv_in(drv_in));

    fdpi_top #(.PULSE_CYC(PC), .GAP_CYC(PC)) dut (.mclk(mclk),
        .rst(rst), .pp_mode(pp_mode), .pin_function_cfg(pin_function_cfg),
        .floppy_cfg_reg(floppy_cfg_reg), .core_cmd(core_cmd),
        .alt_out(alt_out), .pp_data_out(pp_data_out),
        .pp_data_drive(pp_data_drive), .pp_data_in(pp_data_in),
        .drv_o(drv_o), .drv_oe(drv_oe), .drv_in(drv_in),
        .core_drv_in(core_drv_in), .input_pullup_en(input_pullup_en),
        .density_sel_1_i(density_sel_1_i), .density_sel_1_o(den1_o),
        .density_sel_1_oe(den1_oe), .gpio_port1_bit0(gpio_b),
        .kbc_port_bit(kbc_b), .par_data_i(par_data_i),
        .par_data_o(par_data_o), .par_data_oe(par_data_oe),
        .ext_read_data_n(ext_rd_n), .ext_disk_change_n(ext_dc_n));

    // ==========================================================
    // Helpers
    task automatic chk(input string nm, input logic [9:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask : tick

    task automatic test_done;
        if (n_mismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : test_done

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    initial begin
        #20000;
        n_mismatch++;
        test_done();
    end

    // ==========================================================
    // Main sequence
    initial begin
        {rst, removed, prot, hole} = 4'h0;
        rst = 1'b1;
        removed = 1'b1;
        {outer, rd, pp_data_drive, floppy_cfg_reg} = '0;
        pp_mode = PPM_PRINTER;
        pin_function_cfg = 2'h0;
        core_cmd = '0;
        alt_out = '0;
        pp_data_out = 5'h00;
        density_sel_1_i = 1'b1;
        par_data_i = 5'h1f;
        n_mismatch = 0;
        checked = 0;
        tick(4);
        rst = 1'b0;
        chk("oe", drv_oe, '0);
        chk("pullup", input_pullup_en, 1'b1);
        core_cmd = 11'h69d;
        tick(2);
        chk("oe_a", drv_oe, 10'h34e);
        chk("od", drv_o, '0);
        core_cmd = 11'h064;
        tick(2);
        chk("oe_b", drv_oe, 10'h031);
        // Two requests back to back: second must queue, not merge
        core_cmd = '0;
        core_cmd.step_req = 1'b1;
        {nstep, nrise, prev} = '0;
        for (int i = 0; i < 30; i++) begin
            tick(1);
            if (i == 1) core_cmd.step_req = 1'b0;
            nstep += int'(drv_oe.step);
            nrise += int'(drv_oe.step && !prev);
            prev = drv_oe.step;
        end
        chk("step_cyc", 10'(nstep), 10'(2 * PC));
        chk("step_cnt", 10'(nrise), 10'h002);
        floppy_cfg_reg = 8'h80;
        {removed, prot, outer, hole, rd} = 5'h0d;
        tick(3);
        chk("pullup_off", input_pullup_en, 1'b0);
        chk("drv_in", core_drv_in, 5'h11);
        floppy_cfg_reg = 8'h00;
        {removed, prot, outer, hole, rd} = 5'h12;
        tick(3);
        chk("pullup_on", input_pullup_en, 1'b1);
        chk("drv_in2", core_drv_in, 5'h0e);
        // Printer mode: pins carry the port's data bits
        pp_data_out = 5'h15;
        pp_data_drive = 1'b1;
        par_data_i = 5'h0a;
        tick(2);
        chk("pd_o", par_data_o, 5'h15);
        chk("pd_oe", par_data_oe, 5'h1f);
        chk("pd_in", pp_data_in, 5'h0a);
        chk("ext_p", {ext_rd_n, ext_dc_n}, 2'h3);
        // Single extension: motor/select must not reach pins 6 and 7
        pp_mode = PPM_EXT1;
        core_cmd.motor_a = 1'b1;
        core_cmd.select_a = 1'b1;
        par_data_i = 5'h1e;
        tick(2);
        chk("ext1_oe", par_data_oe, 5'h00);
        chk("ext1_rd", {ext_rd_n, ext_dc_n}, 2'h1);
        chk("ext1_in", pp_data_in, 5'h00);
        pp_mode = PPM_EXT2;
        par_data_i = 5'h1d;
        tick(2);
        chk("ext2_oe", par_data_oe, 5'h18);
        chk("ext2_o", par_data_o[4:3], 2'h0);
        chk("ext2_rd", {ext_rd_n, ext_dc_n}, 2'h2);
        core_cmd.motor_a = 1'b0;
        tick(2);
        chk("ext2_mo", par_data_oe, 5'h10);
        // Every role of the density-1 pin
        core_cmd.density = 2'h0;
        alt_out = 5'h1f;
        density_sel_1_i = 1'b0;
        for (int f = 0; f < 4; f++) begin
            pin_function_cfg = 2'(f);
            tick(3);
            chk("den1", {den1_oe, den1_oe ? den1_o : 1'b0, gpio_b, kbc_b},
                4'(16'hbedb >> (4 * f)));
        end
        alt_out.sci_assert = 1'b0;
        tick(2);
        chk("sci_off", {den1_oe, den1_o}, 2'h3);
        test_done();
    end
endmodule : testbench
`default_nettype wire
